/* logic/rfp_ctrl.v */
// Front-panel control: keys, operating levels, parameter editing, access codes,
// LEDs and per-channel signal quality, with an APB register slave.
// Assumes one 250 MHz clock, key pins from outside the clock domain, and
// telegram, interval and alarm inputs from logic on the same clock.
`default_nettype none
`include "rfp_map.vh"

module rfp_ctrl #(
	parameter NCH = 16,
	parameter NPAR = 16,
	parameter PIW = 4,
	parameter GW = 2,
	parameter [35:0] LONG_CYC = `RFP_LONG_MS * `RFP_CLK_KHZ,
	parameter [35:0] TOUT_CYC = `RFP_TOUT_MS * `RFP_CLK_KHZ,
	parameter [35:0] MSG_CYC = `RFP_MSG_MS * `RFP_CLK_KHZ,
	parameter [35:0] BLINK_CYC = `RFP_BLINK_MS * `RFP_CLK_KHZ,
	parameter [35:0] FLASH_CYC = `RFP_FLASH_MS * `RFP_CLK_KHZ
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output wire pready,
	output wire pslverr,
	input wire key_up_n,
	input wire key_down_n,
	input wire key_level_n,
	input wire key_prog_n,
	input wire tlg_valid,
	input wire [3:0] tlg_chan,
	input wire [15:0] ivl_tick,
	input wire [15:0] radio_tout,
	input wire [15:0] alarm1,
	input wire [15:0] alarm2,
	input wire [15:0] low_batt,
	input wire save_err,
	output reg led_green,
	output reg led_red,
	output reg led_yellow,
	output reg [3:0] disp_mode,
	output reg [3:0] disp_chan,
	output reg [6:0] disp_qual,
	output reg [3:0] disp_pidx,
	output reg [15:0] disp_value,
	output reg [1:0] disp_digit
);
	// One-hot operating states.
	localparam [4:0] ST_NORM = 5'h01;
	localparam [4:0] ST_CODE = 5'h02;
	localparam [4:0] ST_MSG = 5'h04;
	localparam [4:0] ST_LINK = 5'h08;
	localparam [4:0] ST_PARAM = 5'h10;

	// Keys are pressed when their pins are low.
	wire [3:0] key_raw = ~{key_prog_n, key_level_n, key_down_n, key_up_n};
	wire [3:0] key_dn; // Debounced pressed level per key.
	reg [3:0] key_dn_d_reg; // Previous debounced level.
	reg [35:0] hold_cnt_reg; // Time the current press has been held.
	reg long_seen_reg; // Long threshold already reached in this press.

	// Three-flop synchroniser per key; a change counts once stages two and three agree.
	genvar k;
	generate
		for (k = 0; k < 4; k = k + 1) begin : g_key
			reg [2:0] sync_reg; // Stage one feeds only stage two.
			reg dn_reg; // Accepted key level.
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					sync_reg <= 3'h0;
					dn_reg <= 1'b0;
				end else begin
					sync_reg <= {sync_reg[1:0], key_raw[k]};
					// Hold the old level while stages disagree.
					if (sync_reg[1] == sync_reg[2]) begin
						dn_reg <= sync_reg[2];
					end
				end
			end
			assign key_dn[k] = dn_reg;
		end
	endgenerate

	// Press classification: one shared hold timer since the panel is used one key at a time.
	wire press_edge = |(key_dn & ~key_dn_d_reg);
	wire long_hit = (hold_cnt_reg == LONG_CYC - 36'h1) && !press_edge;
	wire [3:0] long_ev = key_dn & {4{long_hit}};
	wire [3:0] short_ev = key_dn_d_reg & ~key_dn & {4{~long_seen_reg}};

	// Hold timer restarts on every new press and stops at the long threshold.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			key_dn_d_reg <= 4'h0;
			hold_cnt_reg <= 36'h0;
			long_seen_reg <= 1'b0;
		end else begin
			key_dn_d_reg <= key_dn;
			if (press_edge) begin
				hold_cnt_reg <= 36'h0;
				long_seen_reg <= 1'b0;
			end else if (|key_dn && hold_cnt_reg != LONG_CYC) begin
				hold_cnt_reg <= hold_cnt_reg + 36'h1;
			end
			if (long_hit && |key_dn) begin
				long_seen_reg <= 1'b1;
			end
		end
	end

	// Per-channel reception history over the last five transmission intervals.
	wire [NCH*`RFP_HIST-1:0] hist_flat;
	genvar c;
	generate
		for (c = 0; c < NCH; c = c + 1) begin : g_chan
			reg got_reg; // A telegram arrived in the running interval.
			reg [`RFP_HIST-1:0] hist_reg; // One bit per closed interval.
			wire tel = tlg_valid && (tlg_chan == c);
			always @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					got_reg <= 1'b0;
					hist_reg <= 5'h00;
				end else if (ivl_tick[c]) begin
					// A telegram in the closing cycle still counts for this interval.
					hist_reg <= {hist_reg[3:0], got_reg | tel};
					got_reg <= 1'b0;
				end else if (tel) begin
					got_reg <= 1'b1;
				end
			end
			assign hist_flat[c*`RFP_HIST +: `RFP_HIST] = hist_reg;
		end
	endgenerate

	// Next linked channel in the given direction, wrapping; stays put if none other.
	function [3:0] next_ch;
		input [3:0] cur;
		input [15:0] m;
		input dir;
		integer i;
		reg [3:0] cand;
		reg found;
		begin
			next_ch = cur;
			found = 1'b0;
			for (i = 1; i < 16; i = i + 1) begin
				cand = dir ? cur - i[3:0] : cur + i[3:0];
				if (!found && m[cand]) begin
					next_ch = cand;
					found = 1'b1;
				end
			end
		end
	endfunction

	// Step one decimal digit of a four-digit value up or down, wrapping 9 to 0.
	function [15:0] bcd_step;
		input [15:0] v;
		input [1:0] pos;
		input dn;
		reg [3:0] d;
		begin
			bcd_step = v;
			d = v[pos*4 +: 4];
			if (dn) begin
				d = (d == 4'h0) ? 4'h9 : d - 4'h1;
			end else begin
				d = (d >= 4'h9) ? 4'h0 : d + 4'h1;
			end
			bcd_step[pos*4 +: 4] = d;
		end
	endfunction

	// Software-visible state.
	reg [15:0] link_mask_reg; // Channels linked to a transmitter.
	reg [15:0] num_mask_reg; // Parameters that accept digit entry.
	reg [PIW-1:0] apb_pidx_reg; // Parameter slot reached through PDATA.
	reg [15:0] par_mem [0:NPAR-1]; // Parameter store, codes included.

	// Front-panel state.
	reg [4:0] state_reg;
	reg editing_reg; // A parameter is being edited.
	reg dig_mode_reg; // Digit-by-digit entry active.
	reg [1:0] dig_pos_reg; // Digit under edit, 0 is rightmost.
	reg [PIW-1:0] pidx_reg; // Parameter shown.
	reg [15:0] edit_val_reg; // Value being edited.
	reg [15:0] code_val_reg; // Code being entered.
	reg code_tgt_reg; // Level asked for: 0 linking, 1 parameter.
	reg code_ok_reg; // Result of the last code check.
	reg [35:0] msg_cnt_reg; // Time the code result has been shown.
	reg [35:0] tout_cnt_reg; // Time since the last key press.
	reg qual_view_reg; // Normal view shows quality instead of value.
	reg [3:0] chan_reg; // Channel shown in normal view.

	wire up_s = short_ev[`RFP_KEY_UP];
	wire dn_s = short_ev[`RFP_KEY_DN];
	wire lv_s = short_ev[`RFP_KEY_LVL];
	wire pr_s = short_ev[`RFP_KEY_PRG];
	wire up_l = long_ev[`RFP_KEY_UP];
	wire dn_l = long_ev[`RFP_KEY_DN];
	wire lv_l = long_ev[`RFP_KEY_LVL];
	wire pr_l = long_ev[`RFP_KEY_PRG];
	wire store = state_reg[4] && editing_reg && pr_l;
	wire apb_wr = psel && penable && pwrite;
	wire tout_hit = tout_cnt_reg == TOUT_CYC - 36'h1;
	wire [15:0] link_code = par_mem[`RFP_PAR_LINK_CODE];
	wire [15:0] prm_code = par_mem[`RFP_PAR_PRM_CODE];

	// Main level machine.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg <= ST_NORM;
			editing_reg <= 1'b0;
			dig_mode_reg <= 1'b0;
			dig_pos_reg <= 2'h0;
			pidx_reg <= {PIW{1'b0}};
			edit_val_reg <= 16'h0000;
			code_val_reg <= 16'h0000;
			code_tgt_reg <= 1'b0;
			code_ok_reg <= 1'b0;
			msg_cnt_reg <= 36'h0;
			tout_cnt_reg <= 36'h0;
			qual_view_reg <= 1'b0;
			chan_reg <= 4'h0;
		end else begin
			// Inactivity timer runs only outside normal view and restarts on each press.
			if (press_edge || state_reg[0]) begin
				tout_cnt_reg <= 36'h0;
			end else begin
				tout_cnt_reg <= tout_cnt_reg + 36'h1;
			end
			case (state_reg)
				ST_NORM: begin
					// Keep the shown channel on a linked one, first linked after power-up.
					if (!link_mask_reg[chan_reg] && |link_mask_reg) begin
						chan_reg <= next_ch(chan_reg, link_mask_reg, 1'b0);
					end else if (up_s || dn_s) begin
						chan_reg <= next_ch(chan_reg, link_mask_reg, dn_s);
					end
					if (pr_s) begin
						qual_view_reg <= ~qual_view_reg;
					end
					code_val_reg <= 16'h0000;
					dig_pos_reg <= 2'h0;
					if (lv_l) begin
						// Linking level asks for a code only when one is stored.
						code_tgt_reg <= 1'b0;
						state_reg <= (link_code == 16'h0000) ? ST_LINK : ST_CODE;
					end else if (pr_l) begin
						code_tgt_reg <= 1'b1;
						state_reg <= (prm_code == 16'h0000) ? ST_PARAM : ST_CODE;
					end
				end
				ST_CODE: begin
					// Up/down edit the digit under the cursor, level key moves left.
					if (up_s || dn_s) begin
						code_val_reg <= bcd_step(code_val_reg, dig_pos_reg, dn_s);
					end else if (lv_s && dig_pos_reg != 2'h3) begin
						dig_pos_reg <= dig_pos_reg + 2'h1;
					end else if (pr_l) begin
						code_ok_reg <= code_val_reg == (code_tgt_reg ? prm_code : link_code);
						msg_cnt_reg <= 36'h0;
						state_reg <= ST_MSG;
					end else if (tout_hit) begin
						state_reg <= ST_NORM;
					end
				end
				ST_MSG: begin
					// Result stays up a quarter second, then enter the level or fall back.
					msg_cnt_reg <= msg_cnt_reg + 36'h1;
					if (msg_cnt_reg == MSG_CYC - 36'h1) begin
						if (!code_ok_reg) begin
							state_reg <= ST_NORM;
						end else begin
							state_reg <= code_tgt_reg ? ST_PARAM : ST_LINK;
						end
					end
				end
				ST_LINK: begin
					// Probe linking itself is done elsewhere; only leaving is handled here.
					if (lv_l || tout_hit) begin
						state_reg <= ST_NORM;
					end
				end
				ST_PARAM: begin
					if (lv_l || tout_hit) begin
						// Leaving drops any unsaved edit.
						state_reg <= ST_NORM;
						editing_reg <= 1'b0;
						dig_mode_reg <= 1'b0;
					end else if (!editing_reg) begin
						if (up_s) begin
							pidx_reg <= pidx_reg + 1'b1;
						end else if (dn_s) begin
							pidx_reg <= pidx_reg - 1'b1;
						end else if (up_l) begin
							pidx_reg <= {pidx_reg[PIW-1:GW] + 1'b1, {GW{1'b0}}};
						end else if (dn_l) begin
							pidx_reg <= {pidx_reg[PIW-1:GW] - 1'b1, {GW{1'b0}}};
						end else if (pr_s) begin
							editing_reg <= 1'b1;
							edit_val_reg <= par_mem[pidx_reg];
							dig_mode_reg <= 1'b0;
							dig_pos_reg <= 2'h0;
						end
					end else begin
						if (up_s || dn_s) begin
							if (dig_mode_reg) begin
								edit_val_reg <= bcd_step(edit_val_reg, dig_pos_reg, dn_s);
							end else if (up_s) begin
								edit_val_reg <= edit_val_reg + 16'h0001;
							end else begin
								edit_val_reg <= edit_val_reg - 16'h0001;
							end
						end else if (lv_s && num_mask_reg[pidx_reg]) begin
							// Non-numeric parameters ignore the digit key.
							if (!dig_mode_reg) begin
								dig_mode_reg <= 1'b1;
							end else if (dig_pos_reg != 2'h3) begin
								dig_pos_reg <= dig_pos_reg + 2'h1;
							end
						end else if (pr_l) begin
							editing_reg <= 1'b0;
							dig_mode_reg <= 1'b0;
						end
					end
				end
				default: begin
					state_reg <= ST_NORM;
				end
			endcase
		end
	end

	// Parameter store: a front-panel save wins over a same-cycle bus write.
	integer j;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (j = 0; j < NPAR; j = j + 1) begin
				par_mem[j] <= 16'h0000;
			end
		end else if (store) begin
			par_mem[pidx_reg] <= edit_val_reg;
		end else if (apb_wr && paddr == `RFP_OFF_PDATA) begin
			par_mem[apb_pidx_reg] <= pwdata[15:0];
		end
	end

	// Alarm collection, flash phase and telegram blink.
	reg save_seen_reg; // Save error reported after power-on.
	reg flash_reg; // Red flash phase.
	reg [35:0] flash_cnt_reg;
	reg [35:0] blink_cnt_reg;
	wire alarm_any = |radio_tout || |alarm1 || |alarm2 || |low_batt || save_seen_reg;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			save_seen_reg <= 1'b0;
			flash_reg <= 1'b0;
			flash_cnt_reg <= 36'h0;
			blink_cnt_reg <= 36'h0;
			led_green <= 1'b0;
			led_red <= 1'b0;
			led_yellow <= 1'b0;
		end else begin
			if (save_err) begin
				save_seen_reg <= 1'b1;
			end
			if (flash_cnt_reg == FLASH_CYC - 36'h1) begin
				flash_cnt_reg <= 36'h0;
				flash_reg <= ~flash_reg;
			end else begin
				flash_cnt_reg <= flash_cnt_reg + 36'h1;
			end
			led_green <= !alarm_any;
			led_red <= alarm_any && flash_reg;
			// Each telegram restarts the blink, so telegrams closer together than the blink time keep the LED lit.
			if (tlg_valid) begin
				blink_cnt_reg <= BLINK_CYC;
			end else if (blink_cnt_reg != 36'h0) begin
				blink_cnt_reg <= blink_cnt_reg - 36'h1;
			end
			led_yellow <= tlg_valid || (blink_cnt_reg > 36'h1);
		end
	end

	// Quality of the shown channel: twenty per interval with a telegram.
	wire [4:0] cur_hist = hist_flat[chan_reg*`RFP_HIST +: `RFP_HIST];
	wire [2:0] cur_cnt = {2'h0, cur_hist[0]} + {2'h0, cur_hist[1]} + {2'h0, cur_hist[2]}
		+ {2'h0, cur_hist[3]} + {2'h0, cur_hist[4]};
	wire [6:0] cur_qual = {4'h0, cur_cnt} * `RFP_QSTEP;

	// Display registers follow the state one cycle later.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			disp_mode <= `RFP_DM_VALUE;
			disp_chan <= 4'h0;
			disp_qual <= 7'h00;
			disp_pidx <= 4'h0;
			disp_value <= 16'h0000;
			disp_digit <= 2'h0;
		end else begin
			disp_chan <= chan_reg;
			disp_qual <= cur_qual;
			disp_pidx <= pidx_reg[3:0];
			disp_digit <= dig_pos_reg;
			disp_value <= 16'h0000;
			if (state_reg[0]) begin
				if (link_mask_reg == 16'h0000) begin
					disp_mode <= `RFP_DM_NOLINK;
				end else begin
					disp_mode <= qual_view_reg ? `RFP_DM_QUAL : `RFP_DM_VALUE;
				end
			end else if (state_reg[1]) begin
				disp_mode <= `RFP_DM_CODE;
				disp_value <= code_val_reg;
			end else if (state_reg[2]) begin
				disp_mode <= code_ok_reg ? `RFP_DM_CODE_OK : `RFP_DM_CODE_ERR;
			end else if (state_reg[3]) begin
				disp_mode <= `RFP_DM_LINK;
			end else begin
				disp_mode <= editing_reg ? `RFP_DM_EDIT : `RFP_DM_PARAM;
				disp_value <= editing_reg ? edit_val_reg : par_mem[pidx_reg];
			end
		end
	end

	// APB slave: zero wait states; read data is captured in the setup cycle.
	wire mapped = paddr == `RFP_OFF_STATE || paddr == `RFP_OFF_LINK || paddr == `RFP_OFF_PIDX
		|| paddr == `RFP_OFF_PDATA || paddr == `RFP_OFF_DISP || paddr == `RFP_OFF_NUM
		|| paddr == `RFP_OFF_ALARM;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			link_mask_reg <= 16'h0000;
			num_mask_reg <= 16'h0000;
			apb_pidx_reg <= {PIW{1'b0}};
		end else begin
			if (apb_wr && paddr == `RFP_OFF_LINK) begin
				link_mask_reg <= pwdata[15:0];
			end
			if (apb_wr && paddr == `RFP_OFF_NUM) begin
				num_mask_reg <= pwdata[15:0];
			end
			if (apb_wr && paddr == `RFP_OFF_PIDX) begin
				apb_pidx_reg <= pwdata[PIW-1:0];
			end
			if (psel && !penable) begin
				case (paddr)
					`RFP_OFF_STATE: prdata <= {21'h0, code_ok_reg, code_tgt_reg, dig_pos_reg,
						dig_mode_reg, editing_reg, state_reg};
					`RFP_OFF_LINK: prdata <= {16'h0000, link_mask_reg};
					`RFP_OFF_PIDX: prdata <= {{(32-PIW){1'b0}}, apb_pidx_reg};
					`RFP_OFF_PDATA: prdata <= {16'h0000, par_mem[apb_pidx_reg]};
					`RFP_OFF_DISP: prdata <= {9'h000, disp_qual, pidx_reg[3:0], chan_reg,
						disp_mode, 4'h0};
					`RFP_OFF_NUM: prdata <= {16'h0000, num_mask_reg};
					`RFP_OFF_ALARM: prdata <= {30'h0, save_seen_reg, alarm_any};
					default: prdata <= 32'h00000000;
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* shared/rfp_map.vh */
// Constants for the receiver front-panel control block.
// Assumes inclusion by the design file and the test files; holds definitions and nothing else.
`ifndef RFP_MAP_VH
`define RFP_MAP_VH

// APB register byte offsets, one aligned 32-bit word each.
`define RFP_OFF_STATE 8'h00
`define RFP_OFF_LINK 8'h04
`define RFP_OFF_PIDX 8'h08
`define RFP_OFF_PDATA 8'h0c
`define RFP_OFF_DISP 8'h10
`define RFP_OFF_NUM 8'h14
`define RFP_OFF_ALARM 8'h18

// Key positions inside the internal key vector.
`define RFP_KEY_UP 0
`define RFP_KEY_DN 1
`define RFP_KEY_LVL 2
`define RFP_KEY_PRG 3

// Clock rate and documented times, each in its own unit.
`define RFP_CLK_KHZ 36'h0003d090
`define RFP_LONG_MS 36'h0000007d0
`define RFP_TOUT_MS 36'h000009c40
`define RFP_MSG_MS 36'h0000000fa
`define RFP_BLINK_MS 36'h000000032
`define RFP_FLASH_MS 36'h0000001f4

// Parameter slots that hold the two access codes; zero disables a code.
`define RFP_PAR_LINK_CODE 4'h0
`define RFP_PAR_PRM_CODE 4'h1

// Signal quality step per received interval and history depth.
`define RFP_QSTEP 7'h14
`define RFP_HIST 5

// Display modes shown on disp_mode.
`define RFP_DM_VALUE 4'h0
`define RFP_DM_QUAL 4'h1
`define RFP_DM_NOLINK 4'h2
`define RFP_DM_CODE 4'h3
`define RFP_DM_CODE_OK 4'h4
`define RFP_DM_CODE_ERR 4'h5
`define RFP_DM_LINK 4'h6
`define RFP_DM_PARAM 4'h7
`define RFP_DM_EDIT 4'h8

`endif

/* test/rfp_ctrl_sva.sv */
// Checker for the front-panel block: LEDs, levels, quality and bus errors.
// Assumes it is bound into rfp_ctrl and sees only that module's ports.
`default_nettype none
`include "rfp_map.vh"
module rfp_ctrl_sva #(
	parameter logic [35:0] LONG_CYC = 36'h14,
	parameter logic [35:0] TOUT_CYC = 36'hc8
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pslverr,
	input wire logic key_up_n,
	input wire logic key_down_n,
	input wire logic key_level_n,
	input wire logic key_prog_n,
	input wire logic tlg_valid,
	input wire logic [15:0] radio_tout,
	input wire logic [15:0] alarm1,
	input wire logic [15:0] alarm2,
	input wire logic [15:0] low_batt,
	input wire logic save_err,
	input wire logic led_green,
	input wire logic led_red,
	input wire logic led_yellow,
	input wire logic [3:0] disp_mode,
	input wire logic [6:0] disp_qual
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] hold_lvl; // Cycles the level pin has been held low.
	logic [15:0] hold_prg; // Cycles the program pin has been held low.
	logic [15:0] idle_cnt; // Cycles since the last key was let go.
	logic save_seen; // The save error is sticky, so the checker latches it as well.
	wire logic keys_up = &{key_up_n, key_down_n, key_level_n, key_prog_n};
	wire logic any_alm = |{radio_tout, alarm1, alarm2, low_batt, save_err, save_seen};
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	// Hold and idle counters measured at the pins, before any synchroniser delay.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_lvl <= 16'h0;
			hold_prg <= 16'h0;
			idle_cnt <= 16'h0;
			save_seen <= 1'b0;
		end else begin
			hold_lvl <= key_level_n ? 16'h0 : hold_lvl + 16'h1;
			hold_prg <= key_prog_n ? 16'h0 : hold_prg + 16'h1;
			idle_cnt <= keys_up ? idle_cnt + {15'h0, idle_cnt != 16'hffff} : 16'h0;
			save_seen <= save_seen | save_err;
		end
	end
	property p_green_off; any_alm [*3] |-> !led_green; endproperty
	a_green_off: assert property (p_green_off)
		else $error("green lit during an alarm");
	property p_red_off; !any_alm [*2] |-> !led_red; endproperty
	a_red_off: assert property (p_red_off)
		else $error("red lit without an alarm");
	property p_red_on; $rose(any_alm) |-> ##[1:20] led_red; endproperty
	a_red_on: assert property (p_red_on)
		else $error("red did not flash on an alarm");
	property p_yellow; tlg_valid |=> led_yellow; endproperty
	a_yellow: assert property (p_yellow)
		else $error("yellow did not light after a telegram");
	property p_qual; disp_qual <= 7'h64 && disp_qual % 7'h14 == 7'h0; endproperty
	a_qual: assert property (p_qual)
		else $error("quality not a step of twenty");
	property p_enter_prm;
		disp_mode == `RFP_DM_PARAM && $past(disp_mode) <= 4'h2 |-> hold_prg >= LONG_CYC;
	endproperty
	a_enter_prm: assert property (p_enter_prm)
		else $error("parameter level entered without a long press");
	property p_enter_lnk;
		disp_mode == `RFP_DM_LINK && $past(disp_mode) <= 4'h2 |-> hold_lvl >= LONG_CYC;
	endproperty
	a_enter_lnk: assert property (p_enter_lnk)
		else $error("linking level entered without a long press");
	property p_tout;
		disp_mode inside {4'h3, 4'h6, 4'h7, 4'h8} |-> idle_cnt <= TOUT_CYC + 36'h8;
	endproperty
	a_tout: assert property (p_tout)
		else $error("key timeout did not return to normal view");
	property p_slverr; psel && penable && paddr > 8'h18 |-> pslverr; endproperty
	a_slverr: assert property (p_slverr)
		else $error("unmapped access not flagged");
	c_qual: cover property (disp_mode == `RFP_DM_QUAL);
	c_code_ok: cover property (disp_mode == `RFP_DM_CODE_OK);
	c_edit: cover property (disp_mode == `RFP_DM_EDIT);
endmodule
bind rfp_ctrl rfp_ctrl_sva #(.LONG_CYC(LONG_CYC), .TOUT_CYC(TOUT_CYC)) u_rfp_ctrl_sva (
	.pclk, .presetn, .psel, .penable, .paddr, .pslverr, .key_up_n, .key_down_n,
	.key_level_n, .key_prog_n, .tlg_valid, .radio_tout, .alarm1, .alarm2, .low_batt,
	.save_err, .led_green, .led_red, .led_yellow, .disp_mode, .disp_qual
);
`default_nettype wire

/* test/rfp_keypad_model.sv */
// Operator at the keypad: presses one key at a time, short or long.
// Assumes pclk comes from the bench; the model itself drives the idle key pins high.
`default_nettype none
`include "rfp_map.vh"
module rfp_keypad_model (
	input wire logic pclk,
	output logic key_up_n,
	output logic key_down_n,
	output logic key_level_n,
	output logic key_prog_n
);
	timeunit 1ns;
	timeprecision 1ps;
	// All keys start released.
	initial begin
		{key_up_n, key_down_n, key_level_n, key_prog_n} = 4'hf;
	end
	// Pushes one key; a second key is never held, as the hold timer is shared.
	task automatic push(input int k);
		@(posedge pclk);
		key_up_n <= (k != `RFP_KEY_UP);
		key_down_n <= (k != `RFP_KEY_DN);
		key_level_n <= (k != `RFP_KEY_LVL);
		key_prog_n <= (k != `RFP_KEY_PRG);
	endtask
	// Lets every key go; the model drives each pin high again.
	task automatic lift();
		@(posedge pclk);
		{key_up_n, key_down_n, key_level_n, key_prog_n} <= 4'hf;
	endtask
	// A hold of 8 stays short and 30 passes the long threshold, then a pause.
	task automatic press(input int k, input int hold);
		push(k);
		repeat (hold) @(posedge pclk);
		lift();
		repeat (12) @(posedge pclk);
	endtask
endmodule
`default_nettype wire

/* test/rfp_ctrl_tb_top.sv */
// Self-checking bench for the front-panel block: APB tasks and key sequences.
// Assumes shortened counts: long 20, timeout 200, message 10 cycles.
`default_nettype none
`include "rfp_map.vh"
module rfp_ctrl_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MSG = 10; // Message time chosen for the instance below.
	logic pclk, presetn, psel, penable, pwrite, tlg_valid, save_err, serr, seen;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, led_green, led_red, led_yellow;
	wire logic key_up_n, key_down_n, key_level_n, key_prog_n;
	logic [3:0] tlg_chan, disp_mode, disp_chan, disp_pidx;
	logic [15:0] ivl_tick, radio_tout, alarm1, alarm2, low_batt, disp_value;
	logic [6:0] disp_qual;
	logic [1:0] disp_digit;
	int err_count, n_checks, cnt;
	rfp_ctrl #(.LONG_CYC(36'h14), .TOUT_CYC(36'hc8), .MSG_CYC(36'ha), .BLINK_CYC(36'h4),
		.FLASH_CYC(36'h8)) u_rfp_ctrl (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
		.pwdata, .prdata, .pready, .pslverr, .key_up_n, .key_down_n, .key_level_n,
		.key_prog_n, .tlg_valid, .tlg_chan, .ivl_tick, .radio_tout, .alarm1, .alarm2,
		.low_batt, .save_err, .led_green, .led_red, .led_yellow, .disp_mode, .disp_chan,
		.disp_qual, .disp_pidx, .disp_value, .disp_digit);
	rfp_keypad_model u_keys (.pclk, .key_up_n, .key_down_n, .key_level_n, .key_prog_n);
	// Free-running 250 MHz clock.
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	// Prints the counts and the verdict, then ends the run.
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// Compares one value; case inequality keeps an unknown from matching.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer, held until pready is sampled high; read data lands in rd.
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		rd = prdata;
		serr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50)
			chk("pready", 1, 0);
	endtask
	// Waits a bounded time for a display mode, then checks it; cnt keeps the wait.
	task automatic wait_mode(input logic [3:0] m);
		cnt = 0;
		while (disp_mode !== m && cnt < 400) begin
			@(posedge pclk);
			cnt++;
		end
		chk("disp_mode", m, disp_mode);
	endtask
	// Closes one interval on channel 0, with or without a telegram inside it.
	task automatic ivl(input logic got);
		@(posedge pclk);
		tlg_valid <= got;
		@(posedge pclk);
		tlg_valid <= 1'b0;
		ivl_tick <= 16'h0001;
		@(posedge pclk);
		ivl_tick <= 16'h0;
	endtask
	// Watchdog, far above the expected run of some 1400 cycles.
	initial begin
		repeat (20000) @(posedge pclk);
		err_count++;
		wrap_up();
	end
	// Main sequence.
	initial begin
		{presetn, psel, penable, pwrite, tlg_valid, save_err} = 6'h0;
		{paddr, pwdata, tlg_chan, ivl_tick} = '0;
		{radio_tout, alarm1, alarm2, low_batt} = '0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		repeat (3) @(posedge pclk);
		chk("disp_mode", `RFP_DM_NOLINK, disp_mode);
		chk("led_green", 1, led_green);
		apb(`RFP_OFF_LINK, 1'b1, 32'h5);
		apb(`RFP_OFF_LINK, 1'b0, 32'h0);
		chk("link", 32'h5, rd);
		apb(8'h1c, 1'b0, 32'h0);
		chk("pslverr", 1, serr);
		repeat (3) @(posedge pclk);
		chk("disp_mode", `RFP_DM_VALUE, disp_mode);
		chk("disp_chan", 0, disp_chan);
		u_keys.press(`RFP_KEY_UP, 8);
		chk("disp_chan", 2, disp_chan);
		u_keys.press(`RFP_KEY_DN, 8);
		chk("disp_chan", 0, disp_chan);
		ivl(1'b1);
		ivl(1'b1);
		ivl(1'b0);
		ivl(1'b1);
		ivl(1'b0);
		u_keys.press(`RFP_KEY_PRG, 8);
		chk("disp_mode", `RFP_DM_QUAL, disp_mode);
		chk("disp_qual", 3 * `RFP_QSTEP, disp_qual);
		u_keys.press(`RFP_KEY_PRG, 8);
		u_keys.press(`RFP_KEY_PRG, 30);
		chk("disp_mode", `RFP_DM_PARAM, disp_mode);
		u_keys.press(`RFP_KEY_UP, 8);
		chk("disp_pidx", 1, disp_pidx);
		u_keys.press(`RFP_KEY_UP, 30);
		chk("disp_pidx", 4, disp_pidx);
		u_keys.press(`RFP_KEY_DN, 30);
		chk("disp_pidx", 0, disp_pidx);
		repeat (2) u_keys.press(`RFP_KEY_UP, 8);
		u_keys.press(`RFP_KEY_PRG, 8);
		chk("disp_mode", `RFP_DM_EDIT, disp_mode);
		u_keys.press(`RFP_KEY_LVL, 8);
		apb(`RFP_OFF_STATE, 1'b0, 32'h0);
		chk("digit mode", 0, rd[6]);
		repeat (2) u_keys.press(`RFP_KEY_UP, 8);
		chk("disp_value", 2, disp_value);
		apb(`RFP_OFF_NUM, 1'b1, 32'h4);
		u_keys.press(`RFP_KEY_LVL, 8);
		apb(`RFP_OFF_STATE, 1'b0, 32'h0);
		chk("digit mode", 1, rd[6]);
		u_keys.press(`RFP_KEY_LVL, 8);
		chk("disp_digit", 1, disp_digit);
		u_keys.press(`RFP_KEY_PRG, 30);
		apb(`RFP_OFF_PIDX, 1'b1, 32'h2);
		apb(`RFP_OFF_PDATA, 1'b0, 32'h0);
		chk("stored", 2, rd);
		u_keys.press(`RFP_KEY_LVL, 30);
		chk("disp_mode", `RFP_DM_VALUE, disp_mode);
		// Set a parameter-level code of 3, then enter it right and wrong.
		apb(`RFP_OFF_PIDX, 1'b1, 32'h1);
		apb(`RFP_OFF_PDATA, 1'b1, 32'h3);
		u_keys.press(`RFP_KEY_PRG, 30);
		chk("disp_mode", `RFP_DM_CODE, disp_mode);
		repeat (3) u_keys.press(`RFP_KEY_UP, 8);
		u_keys.push(`RFP_KEY_PRG);
		wait_mode(`RFP_DM_CODE_OK);
		wait_mode(`RFP_DM_PARAM);
		chk("message time", 1, cnt >= MSG - 1 && cnt <= MSG + 1);
		u_keys.lift();
		repeat (12) @(posedge pclk);
		u_keys.press(`RFP_KEY_LVL, 30);
		u_keys.press(`RFP_KEY_PRG, 30);
		u_keys.press(`RFP_KEY_UP, 8);
		u_keys.push(`RFP_KEY_PRG);
		wait_mode(`RFP_DM_CODE_ERR);
		wait_mode(`RFP_DM_VALUE);
		u_keys.lift();
		repeat (12) @(posedge pclk);
		// Linking code is still zero, so the level opens without a code.
		u_keys.press(`RFP_KEY_LVL, 30);
		chk("disp_mode", `RFP_DM_LINK, disp_mode);
		repeat (120) @(posedge pclk);
		u_keys.press(`RFP_KEY_UP, 8);
		repeat (150) @(posedge pclk);
		chk("disp_mode", `RFP_DM_LINK, disp_mode);
		wait_mode(`RFP_DM_VALUE);
		// Each alarm source in turn; the save error stays latched.
		for (int i = 0; i < 5; i++) begin
			radio_tout <= (i == 0) ? 16'h8000 : 16'h0;
			alarm1 <= (i == 1) ? 16'h0001 : 16'h0;
			alarm2 <= (i == 2) ? 16'h0100 : 16'h0;
			low_batt <= (i == 3) ? 16'h0010 : 16'h0;
			save_err <= (i == 4);
			seen = 1'b0;
			repeat (24) begin
				@(posedge pclk);
				seen = seen | led_red;
			end
			chk("led_green", 0, led_green);
			chk("led_red", 1, seen);
			{radio_tout, alarm1, alarm2, low_batt, save_err} <= '0;
			repeat (4) @(posedge pclk);
			chk("led_green", i != 4, led_green);
		end
		wrap_up();
	end
endmodule
`default_nettype wire
